// File: src/uart_channel_pair.sv
/*
  Start-stop serial channel pair: channel 0 transmits on tx_pin and
  channel 1 receives on rx_pin, with registers on AXI4-Lite. Assumes
  rx_pin already synchronous to aclk and one clock domain.
*/
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`include "uart_defs.svh"

// Overview of operation
// - Frame: start, data, parity, stop bits
// - Even channel sends, odd channel receives
// - Data length selectable 7, 8, 9
// - MSB-first or LSB-first shifting selectable
// - Line inversion selectable for both directions
// - Parity none, zero, even, odd; even and odd checked
// - One or two stop bits; stop checked
// - Transmit event: frame end or buffer empty
// - Framing, parity, overrun raise error event
// - Nine-bit mode sends data bits 0-8
// - Start bit runs only that channel
// - Halt bit clears channel running flag
// - Drive disabled: line free for software
// - Clock gate off resets whole unit
// - Channel 0 transmits, channel 1 receives
// - Wake mode receives during low-power stop
// - Operation clock from one of two prescalers
module uart_channel_pair
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address
  input  wire logic [`ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              awvalid,
  output logic                   awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  // AXI4-Lite write response
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read address
  input  wire logic [`ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  input  wire logic              arvalid,
  output logic                   arready,
  // AXI4-Lite read data
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Clock gate and low-power state
  input  wire logic              periph_clk_en,
  input  wire logic              low_power_stop,
  // Serial lines
  input  wire logic              rx_pin,
  output logic                   tx_pin,
  // Channel events
  output logic                   tx_irq,
  output logic                   rx_irq,
  output logic                   rx_err_irq
);
  import uart_pkg::*;

  pair_state_s s;
  pair_state_s next_s;
  logic        unit_rst_n;
  logic        tick_tx;
  logic        tick_rx;
  logic        wr_go;
  logic [31:0] mk;
  logic [31:0] wv;
  logic [31:0] t;
  logic [32:0] rw;
  logic [12:0] f;
  logic        rxb;
  logic [3:0]  dn;
  logic [8:0]  raw;
  logic        pbit;
  logic        perr;
  logic        ferr;
  logic        oerr;

  // Byte-lane mask from write strobes
  function automatic logic [31:0] strb_mask(input logic [3:0] b);
    strb_mask = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
  endfunction

  // Data field length in bits
  function automatic logic [3:0] dlen(input logic [1:0] l);
    case (l)
      `LEN_7:  dlen = `DLEN_7;
      `LEN_9:  dlen = `DLEN_9;
      default: dlen = `DLEN_8;
    endcase
  endfunction

  // Bits after the start bit up to the first stop bit
  function automatic logic [3:0] rx_bits(input logic [10:0] c);
    rx_bits = dlen(c[`C_LEN]) + {3'h0, c[`C_PAR] != `PAR_NONE} + 4'h1;
  endfunction

  // Whole transmitted frame length
  function automatic logic [3:0] tx_bits(input logic [10:0] c);
    tx_bits = rx_bits(c) + 4'h1 + {3'h0, c[`C_STOP2]};
  endfunction

  // One bit period minus one, in operation clock ticks
  function automatic logic [7:0] per_m1(input logic [6:0] d);
    per_m1 = {d, 1'h1};
  endfunction

  // Reverse the low n bits
  function automatic logic [8:0] rev(input logic [8:0] d, input logic [3:0] n);
    rev = '0;
    for (int i = 0; i < 9; i++)
      if (i < n)
        rev[i] = d[n - 1 - i];
  endfunction

  // Frame bits, first to send in bit 0
  function automatic logic [12:0] frame(input logic [8:0] d, input logic [10:0] c);
    logic [3:0] n;
    logic [8:0] m;
    logic [8:0] o;
    logic       pb;
    n = dlen(c[`C_LEN]);
    m = d & ~(9'h1ff << n);
    o = c[`C_MSB] ? rev(m, n) : m;
    case (c[`C_PAR])
      `PAR_EVEN: pb = ^m;
      `PAR_ODD:  pb = ~^m;
      default:   pb = 1'h0;
    endcase
    frame    = '1;
    frame[0] = 1'h0;
    for (int i = 0; i < 9; i++)
      if (i < n)
        frame[i + 1] = o[i];
    if (c[`C_PAR] != `PAR_NONE)
      frame[n + 4'h1] = pb;
  endfunction

  // Register read mux: bit 32 marks a mapped address
  function automatic logic [32:0] rd_word(input pair_state_s st, input logic [7:0] a);
    rd_word = {1'h1, 32'h0};
    case (a)
      `OFF_TX_DATA: rd_word[31:0] = {16'h0, st.tx_div, st.tx_buf};
      `OFF_RX_DATA: rd_word[31:0] = {16'h0, st.rx_div, st.rx_buf};
      `OFF_CTRL:    rd_word[`F_CTRL] = st.ctrl;
      `OFF_PSEL:    rd_word[`F_PSEL] = st.psel;
      `OFF_STATUS:
      begin
        rd_word[`S_TX_RUN]  = st.tx_run;
        rd_word[`S_RX_RUN]  = st.rx_run;
        rd_word[`S_TX_FULL] = st.tx_full;
        rd_word[`S_TX_BUSY] = (st.txs == TX_SEND);
        rd_word[`S_RX_FULL] = st.rx_full;
        rd_word[`S_FE]      = st.fe;
        rd_word[`S_PE]      = st.pe;
        rd_word[`S_OVF]     = st.ovf;
      end
      `OFF_START,
      `OFF_HALT:    ;
      `OFF_LEVEL:   rd_word[`F_FLAG] = st.line;
      `OFF_DRIVE:   rd_word[`F_FLAG] = st.drive_en;
      default:      rd_word[32] = 1'h0;
    endcase
  endfunction

  // Clock gate off holds the unit in reset
  assign unit_rst_n = aresetn & periph_clk_en;

  // Operation clock ticks for both channels
  uart_prescaler u_presc
  (
    .aclk    (aclk),
    .rst_n   (unit_rst_n),
    .psel    (s.psel),
    .pick_tx (s.ctrl[`C_PICK_TX]),
    .pick_rx (s.ctrl[`C_PICK_RX]),
    .tick_tx (tick_tx),
    .tick_rx (tick_rx)
  );

  // Next-state logic: transmitter, bus, then receiver so sets win
  always_comb
  begin
    next_s            = s;
    wr_go             = s.aw_hold && s.w_hold && !s.bvalid;
    mk                = strb_mask(s.wstb);
    wv                = (32'(rd_word(s, s.waddr)) & ~mk) | (s.wdat & mk);
    t                 = s.wdat & mk;
    rw                = rd_word(s, araddr);
    f                 = frame(s.tx_buf, s.ctrl);
    rxb               = rx_pin ^ s.ctrl[`C_INV];
    dn                = dlen(s.ctrl[`C_LEN]);
    raw               = s.rx_sh[8:0] & ~(9'h1ff << dn);
    pbit              = s.rx_sh[dn];
    perr              = 1'h0;
    ferr              = 1'h0;
    oerr              = 1'h0;
    next_s.tx_irq     = 1'h0;
    next_s.rx_irq     = 1'h0;
    next_s.rx_err_irq = 1'h0;

    // Transmit channel 0
    case (s.txs)
      TX_IDLE:
        if (s.tx_run && s.tx_full)
        begin
          next_s.txs     = TX_SEND;
          next_s.tx_full = 1'h0;
          next_s.tx_sh   = f[12:1];
          next_s.tx_left = tx_bits(s.ctrl) - 4'h1;
          next_s.tx_cnt  = per_m1(s.tx_div);
          next_s.tx_irq  = s.ctrl[`C_CONT];
          if (s.drive_en)
            next_s.line = f[0] ^ s.ctrl[`C_INV];
        end
        else if (s.tx_run && s.drive_en)
          next_s.line = ~s.ctrl[`C_INV];
      TX_SEND:
        if (!s.tx_run)
          next_s.txs = TX_IDLE;
        else if (tick_tx && s.tx_cnt != 8'h00)
          next_s.tx_cnt = s.tx_cnt - 8'h01;
        else if (tick_tx && s.tx_left == 4'h0)
        begin
          next_s.txs    = TX_IDLE;
          next_s.tx_irq = !s.ctrl[`C_CONT];
        end
        else if (tick_tx)
        begin
          next_s.tx_sh   = s.tx_sh >> 1;
          next_s.tx_left = s.tx_left - 4'h1;
          next_s.tx_cnt  = per_m1(s.tx_div);
          if (s.drive_en)
            next_s.line = s.tx_sh[0] ^ s.ctrl[`C_INV];
        end
      default: next_s.txs = TX_IDLE;
    endcase

    // Bus write channels
    if (awvalid && s.awready)
    begin
      next_s.aw_hold = 1'h1;
      next_s.awready = 1'h0;
      next_s.waddr   = awaddr;
    end
    if (wvalid && s.wready)
    begin
      next_s.w_hold = 1'h1;
      next_s.wready = 1'h0;
      next_s.wdat   = wdata;
      next_s.wstb   = wstrb;
    end
    if (s.bvalid && bready)
    begin
      next_s.bvalid  = 1'h0;
      next_s.awready = 1'h1;
      next_s.wready  = 1'h1;
    end

    // Register write effects
    if (wr_go)
    begin
      next_s.aw_hold = 1'h0;
      next_s.w_hold  = 1'h0;
      next_s.bvalid  = 1'h1;
      next_s.bresp   = `RESP_OKAY;
      case (s.waddr)
        `OFF_TX_DATA:
        begin
          next_s.tx_div  = wv[`F_DIV];
          next_s.tx_buf  = wv[`F_DATA];
          next_s.tx_full = 1'h1;
        end
        `OFF_RX_DATA: next_s.rx_div = wv[`F_DIV];
        `OFF_CTRL:    next_s.ctrl   = wv[`F_CTRL];
        `OFF_PSEL:    next_s.psel   = wv[`F_PSEL];
        `OFF_STATUS:
        begin
          if (t[`S_FE])
            next_s.fe = 1'h0;
          if (t[`S_PE])
            next_s.pe = 1'h0;
          if (t[`S_OVF])
            next_s.ovf = 1'h0;
        end
        `OFF_START:
        begin
          if (t[`CH_TX])
            next_s.tx_run = 1'h1;
          if (t[`CH_RX])
            next_s.rx_run = 1'h1;
        end
        `OFF_HALT:
        begin
          if (t[`CH_TX])
            next_s.tx_run = 1'h0;
          if (t[`CH_RX])
            next_s.rx_run = 1'h0;
        end
        `OFF_LEVEL:
          if (!s.drive_en)
            next_s.line = wv[`F_FLAG];
        `OFF_DRIVE:   next_s.drive_en = wv[`F_FLAG];
        default:      next_s.bresp = `RESP_SLVERR;
      endcase
    end

    // Bus read channels
    if (s.rvalid && rready)
    begin
      next_s.rvalid  = 1'h0;
      next_s.arready = 1'h1;
    end
    if (arvalid && s.arready)
    begin
      next_s.rvalid  = 1'h1;
      next_s.arready = 1'h0;
      next_s.rdata   = rw[31:0];
      next_s.rresp   = rw[32] ? `RESP_OKAY : `RESP_SLVERR;
      if (araddr == `OFF_RX_DATA)
        next_s.rx_full = 1'h0;
    end

    // Receive channel 1
    case (s.rxs)
      RX_IDLE:
        if (s.rx_run && !rxb && (!low_power_stop || s.ctrl[`C_WAKE]))
        begin
          next_s.rxs    = RX_START;
          next_s.rx_cnt = {1'h0, s.rx_div};
        end
      RX_START:
        if (!s.rx_run)
          next_s.rxs = RX_IDLE;
        else if (tick_rx && s.rx_cnt != 8'h00)
          next_s.rx_cnt = s.rx_cnt - 8'h01;
        else if (tick_rx && rxb)
          next_s.rxs = RX_IDLE;
        else if (tick_rx)
        begin
          next_s.rxs    = RX_DATA;
          next_s.rx_idx = 4'h0;
          next_s.rx_cnt = per_m1(s.rx_div);
        end
      RX_DATA:
        if (!s.rx_run)
          next_s.rxs = RX_IDLE;
        else if (tick_rx && s.rx_cnt != 8'h00)
          next_s.rx_cnt = s.rx_cnt - 8'h01;
        else if (tick_rx && s.rx_idx == rx_bits(s.ctrl) - 4'h1)
        begin
          perr = ((s.ctrl[`C_PAR] == `PAR_EVEN) && (^raw ^ pbit)) ||
                 ((s.ctrl[`C_PAR] == `PAR_ODD) && !(^raw ^ pbit));
          ferr = !rxb;
          oerr = next_s.rx_full;
          next_s.rxs        = RX_IDLE;
          next_s.rx_buf     = s.ctrl[`C_MSB] ? rev(raw, dn) : raw;
          next_s.rx_full    = 1'h1;
          next_s.rx_irq     = 1'h1;
          next_s.fe         = next_s.fe | ferr;
          next_s.pe         = next_s.pe | perr;
          next_s.ovf        = next_s.ovf | oerr;
          next_s.rx_err_irq = perr | ferr | oerr;
        end
        else if (tick_rx)
        begin
          next_s.rx_sh[s.rx_idx] = rxb;
          next_s.rx_idx          = s.rx_idx + 4'h1;
          next_s.rx_cnt          = per_m1(s.rx_div);
        end
      default: next_s.rxs = RX_IDLE;
    endcase
  end

  // State register; gate-off acts like reset
  always_ff @(posedge aclk)
  begin
    if (!unit_rst_n)
    begin
      s         <= '0;
      s.awready <= 1'h1;
      s.wready  <= 1'h1;
      s.arready <= 1'h1;
      s.ctrl    <= `CTRL_RST;
      s.psel    <= `PSEL_RST;
      s.tx_div  <= `DIV_RST;
      s.rx_div  <= `DIV_RST;
      s.line    <= `LINE_RST;
    end
    else
      s <= next_s;
  end

  // Outputs straight from the state register
  assign awready    = s.awready;
  assign wready     = s.wready;
  assign bresp      = s.bresp;
  assign bvalid     = s.bvalid;
  assign arready    = s.arready;
  assign rdata      = s.rdata;
  assign rresp      = s.rresp;
  assign rvalid     = s.rvalid;
  assign tx_pin     = s.line;
  assign tx_irq     = s.tx_irq;
  assign rx_irq     = s.rx_irq;
  assign rx_err_irq = s.rx_err_irq;

  // Checks on the channel behaviour
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_idle_level;
    (s.tx_run && s.drive_en && s.txs == TX_IDLE && periph_clk_en)
      |=> (s.txs == TX_SEND || s.line == ~$past(s.ctrl[`C_INV]));
  endproperty
  a_idle_level: assert property (p_idle_level)
    else $error("idle transmit line not at idle level");

  property p_start_bit;
    (s.txs == TX_SEND && $past(s.txs) == TX_IDLE && $past(s.drive_en))
      |-> s.line == $past(s.ctrl[`C_INV]);
  endproperty
  a_start_bit: assert property (p_start_bit)
    else $error("frame did not open with a start bit");

  property p_nine_bits;
    (s.txs == TX_SEND && $past(s.txs) == TX_IDLE && $past(s.ctrl[`C_LEN]) == `LEN_9 &&
     $past(s.ctrl[`C_PAR]) == `PAR_NONE && !$past(s.ctrl[`C_STOP2]))
      |-> s.tx_left == 4'ha;
  endproperty
  a_nine_bits: assert property (p_nine_bits)
    else $error("nine-bit frame length wrong");

  property p_stop_level;
    ($past(s.txs) == TX_SEND && s.txs == TX_IDLE && $past(s.tx_run) && $past(s.drive_en)
     && periph_clk_en)
      |-> $past(s.line) == ~$past(s.ctrl[`C_INV]);
  endproperty
  a_stop_level: assert property (p_stop_level)
    else $error("frame did not end on a stop bit");

  property p_halt;
    (wr_go && s.waddr == `OFF_HALT && s.wdat[`CH_TX] && s.wstb[0]) |=> !s.tx_run ##1 s.txs == TX_IDLE;
  endproperty
  a_halt: assert property (p_halt)
    else $error("halt did not stop the transmit channel");

  property p_start;
    (wr_go && s.waddr == `OFF_START && s.wdat[`CH_RX] && s.wstb[0] && periph_clk_en)
      |=> s.rx_run;
  endproperty
  a_start: assert property (p_start)
    else $error("start did not run the receive channel");

  property p_line_free;
    (!s.drive_en && !(wr_go && s.waddr == `OFF_LEVEL) && periph_clk_en) |=> $stable(s.line);
  endproperty
  a_line_free: assert property (p_line_free)
    else $error("line changed while drive disabled");

  property p_empty_event;
    (s.txs == TX_SEND && $past(s.txs) == TX_IDLE && $past(s.ctrl[`C_CONT])) |-> s.tx_irq;
  endproperty
  a_empty_event: assert property (p_empty_event)
    else $error("buffer-empty event missing");

  property p_err_flag;
    s.rx_err_irq |-> (s.fe || s.pe || s.ovf) && s.rx_irq && s.rx_full;
  endproperty
  a_err_flag: assert property (p_err_flag)
    else $error("error event without error flag");

  property p_sleep;
    (s.rxs == RX_IDLE && low_power_stop && !s.ctrl[`C_WAKE]) |=> s.rxs == RX_IDLE;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("reception started in stop without wake mode");

  property p_gate;
    !periph_clk_en |=> (!s.tx_run && !s.rx_run && s.line == `LINE_RST);
  endproperty
  a_gate: assert property (p_gate)
    else $error("clock gate did not reset the unit");

  c_tx_frame:  cover property (s.txs == TX_SEND ##1 s.txs == TX_IDLE);
  c_rx_frame:  cover property (s.rx_irq && !s.rx_err_irq);
  c_rx_error:  cover property (s.rx_err_irq);
  c_bad_addr:  cover property (s.bvalid && s.bresp == `RESP_SLVERR);

endmodule

// File: src/uart_defs.svh
/*
  Register map, field positions, encodings and reset values of the
  serial channel pair. Assumes byte addresses on an 8-bit window and
  32-bit AXI4-Lite data.
*/
`ifndef UART_DEFS_SVH
`define UART_DEFS_SVH

// Bus geometry
`define ADDR_W      8

// Register byte offsets
`define OFF_TX_DATA 8'h00
`define OFF_RX_DATA 8'h04
`define OFF_CTRL    8'h08
`define OFF_PSEL    8'h0c
`define OFF_STATUS  8'h10
`define OFF_START   8'h14
`define OFF_HALT    8'h18
`define OFF_LEVEL   8'h1c
`define OFF_DRIVE   8'h20

// Register value fields
`define F_DIV       15:9
`define F_DATA      8:0
`define F_CTRL      10:0
`define F_PSEL      7:0
`define F_FLAG      0

// Control register fields
`define C_LEN       1:0
`define C_MSB       2
`define C_INV       3
`define C_PAR       5:4
`define C_STOP2     6
`define C_CONT      7
`define C_PICK_TX   8
`define C_PICK_RX   9
`define C_WAKE      10

// Prescaler select fields
`define P_SEL0      3:0
`define P_SEL1      7:4

// Status bits
`define S_TX_RUN    0
`define S_RX_RUN    1
`define S_TX_FULL   2
`define S_TX_BUSY   3
`define S_RX_FULL   4
`define S_FE        5
`define S_PE        6
`define S_OVF       7

// Channel bits of the start and halt registers
`define CH_TX       0
`define CH_RX       1

// Encodings
`define LEN_7       2'h1
`define LEN_8       2'h2
`define LEN_9       2'h3
`define DLEN_7      4'h7
`define DLEN_8      4'h8
`define DLEN_9      4'h9
`define PAR_NONE    2'h0
`define PAR_ZERO    2'h1
`define PAR_EVEN    2'h2
`define PAR_ODD     2'h3
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

// Reset values
`define CTRL_RST    11'h002
`define PSEL_RST    8'h00
`define DIV_RST     7'h00
`define LINE_RST    1'h1

`endif

// File: src/uart_pkg.sv
/*
  Types of the serial channel pair: state enums and the state records.
  Assumes nothing beyond the register layout header.
*/
package uart_pkg;

  typedef enum logic [0:0] {TX_IDLE, TX_SEND} tx_state_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} rx_state_e;

  typedef struct packed {
    logic [14:0] cnt;
    logic        tick_tx;
    logic        tick_rx;
  } presc_state_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic        aw_hold;
    logic        w_hold;
    logic [7:0]  waddr;
    logic [31:0] wdat;
    logic [3:0]  wstb;
    logic [10:0] ctrl;
    logic [7:0]  psel;
    logic [6:0]  tx_div;
    logic [6:0]  rx_div;
    logic [8:0]  tx_buf;
    logic        tx_full;
    logic [8:0]  rx_buf;
    logic        rx_full;
    logic        tx_run;
    logic        rx_run;
    logic        fe;
    logic        pe;
    logic        ovf;
    logic        drive_en;
    logic        line;
    tx_state_e   txs;
    logic [11:0] tx_sh;
    logic [3:0]  tx_left;
    logic [7:0]  tx_cnt;
    rx_state_e   rxs;
    logic [9:0]  rx_sh;
    logic [3:0]  rx_idx;
    logic [7:0]  rx_cnt;
    logic        tx_irq;
    logic        rx_irq;
    logic        rx_err_irq;
  } pair_state_s;

endpackage

// File: src/uart_prescaler.sv
/*
  Two power-of-two prescalers sharing one counter, and the per-channel
  choice of operation clock tick. Assumes one system clock and a
  synchronous active-low reset.
*/
`timescale 1ns/10ps
`include "uart_defs.svh"

module uart_prescaler
(
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       rst_n,
  // Prescaler selects and channel picks
  input  wire logic [7:0] psel,
  input  wire logic       pick_tx,
  input  wire logic       pick_rx,
  // Operation clock ticks
  output logic            tick_tx,
  output logic            tick_rx
);
  import uart_pkg::*;

  presc_state_s s;
  presc_state_s next_s;
  logic         t0;
  logic         t1;

  // True once every 2^k system clocks
  function automatic logic due(input logic [14:0] c, input logic [3:0] k);
    logic [14:0] m;
    m   = 15'h7fff >> (4'hf - k);
    due = ((c & m) == m);
  endfunction

  // Divider chain and tick selection
  always_comb
  begin
    next_s         = s;
    next_s.cnt     = s.cnt + 15'h0001;
    t0             = due(s.cnt, psel[`P_SEL0]);
    t1             = due(s.cnt, psel[`P_SEL1]);
    next_s.tick_tx = pick_tx ? t1 : t0;
    next_s.tick_rx = pick_rx ? t1 : t0;
  end

  // State register
  always_ff @(posedge aclk)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign tick_tx = s.tick_tx;
  assign tick_rx = s.tick_rx;

endmodule

// File: dv/uart_far_end.sv
/*
  Far-end serial device: captures frames from the transmit line and
  sends frames on the receive line. Assumes BIT aclk cycles per captured
  bit; sent frames take their own bit length.
*/
`timescale 1ns/10ps
module uart_far_end
#(
  parameter int BIT = 6
)
(
  // Clock
  input  wire logic aclk,
  // Serial lines
  input  wire logic line_in,
  output logic      line_out
);
  logic [12:0] got;

  // Idle line is pulled high
  initial line_out = 1'b1;

  // Wait for a start edge, then sample mid-bit
  task automatic grab(input int n, input logic idle);
    int i;
    while (line_in === idle) @(posedge aclk);
    repeat (BIT / 2) @(posedge aclk);
    for (i = 0; i < n; i++)
    begin
      got[i] = line_in;
      repeat (BIT) @(posedge aclk);
    end
  endtask

  // Send frame bits at b cycles per bit
  task automatic send(input logic [12:0] f, input int n, input int b);
    int i;
    for (i = 0; i < n; i++)
    begin
      line_out <= f[i];
      repeat (b) @(posedge aclk);
    end
    line_out <= 1'b1;
  endtask
endmodule

// File: dv/uart_channel_pair_tb.sv
/*
  Bench of the serial channel pair: register tasks on AXI4-Lite and
  frame checks via the far end. Assumes divider 2; prescaler 0 except
  in the clock gate scenario, which receives at half rate.
*/
`timescale 1ns/10ps
module uart_channel_pair_tb;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, rx_pin, tx_pin, rx_err_irq, ers;
  logic        tx_irq, rx_irq, gate, lps;
  int          ntx = 0;
  int          nrx = 0;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [1:0]  bresp, rresp;
  int          num_errors = 0;
  int          num_checks = 0;
  int          n;

  uart_channel_pair dut_u (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready,
    .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .periph_clk_en(gate), .low_power_stop(lps), .rx_pin, .tx_pin, .tx_irq,
    .rx_irq, .rx_err_irq);
  uart_far_end far_u (.aclk, .line_in(tx_pin), .line_out(rx_pin));

  // Clock, sticky error event and event counts
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    if (rx_err_irq === 1'b1) ers <= 1'b1;
    if (tx_irq === 1'b1) ntx <= ntx + 1;
    if (rx_irq === 1'b1) nrx <= nrx + 1;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Register write; response ready held high throughout
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
  endtask

  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    v = rdata;
  endtask

  // Expected line bits of one frame, first bit at index 0
  function automatic logic [12:0] frm(input logic [10:0] c, input logic [8:0] d,
                                      output int nb);
    int   k, m;
    logic p;
    m = (c[1:0] == 2'h1) ? 7 : (c[1:0] == 2'h3) ? 9 : 8;
    frm = 13'h0;
    p = 1'b0;
    for (k = 0; k < m; k++)
    begin
      frm[1 + k] = c[2] ? d[m - 1 - k] : d[k];
      p = p ^ d[k];
    end
    nb = m + 1;
    frm[nb] = (p ^ c[4]) & c[5];
    nb = nb + int'(c[5:4] != 2'h0);
    frm[nb] = 1'b1;
    nb = nb + 1 + int'(c[6]);
    frm[nb - 1] = 1'b1;
    if (c[3]) frm = ~frm;
  endfunction

  task automatic tx_case(input logic [10:0] c);
    logic [12:0] e, mk;
    e = frm(c, 9'h1a5, n);
    mk = 13'((1 << n) - 1);
    wr(8'h08, {21'h0, c});
    repeat (2) @(posedge aclk);
    chk(tx_pin, {31'h0, ~c[3]});
    fork
      wr(8'h00, 32'h5a5);
      far_u.grab(n, ~c[3]);
    join
    chk(far_u.got & mk, e & mk);
  endtask

  task automatic t_main;
    rd(8'h08);
    chk(v, 32'h2);
    rd(8'h24);
    chk(rresp, 2'h2);
    wr(8'h1c, 32'h1);
    wr(8'h20, 32'h1);
    wr(8'h14, 32'h1);
    tx_case(11'h002);
    tx_case(11'h065);
    tx_case(11'h01b);
    tx_case(11'h032);
    tx_case(11'h083);
    chk(ntx, 5);
  endtask

  // Receive a frame with a wrong parity bit
  task automatic t_rx;
    logic [12:0] e;
    e = frm(11'h022, 9'h03c, n);
    e[9] = ~e[9];
    wr(8'h04, 32'h400);
    wr(8'h08, 32'h22);
    wr(8'h14, 32'h2);
    far_u.send(e, n, 6);
    repeat (4) @(posedge aclk);
    chk(ers, 1'b1);
    rd(8'h04);
    chk(v, 32'h43c);
    rd(8'h10);
    chk(v & 32'hf0, 32'h40);
    wr(8'h18, 32'h1);
    rd(8'h10);
    chk(v & 32'h3, 32'h2);
  endtask

  // Gate pulse resets the unit; half-rate receive setup, then sleep and wake reception
  task automatic t_gate;
    logic [12:0] e;
    e = frm(11'h002, 9'h0a5, n);
    wr(8'h18, 32'h3);
    gate <= 1'b0;
    @(posedge aclk);
    gate <= 1'b1;
    @(posedge aclk);
    rd(8'h08);
    chk(v, 32'h2);
    rd(8'h10);
    chk(v & 32'hff, 32'h0);
    wr(8'h04, 32'h400);
    wr(8'h0c, 32'h10);
    lps <= 1'b1;
    wr(8'h08, 32'h202);
    wr(8'h14, 32'h2);
    far_u.send(e, n, 12);
    repeat (4) @(posedge aclk);
    chk(nrx, 1);
    wr(8'h08, 32'h602);
    far_u.send(e, n, 12);
    repeat (8) @(posedge aclk);
    chk(nrx, 2);
    rd(8'h04);
    chk(v, 32'h4a5);
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Reset, then run the scenarios
  initial
  begin
    {aresetn, awvalid, wvalid, arvalid, ers, lps, awaddr, araddr, wdata} = '0;
    {bready, rready, gate} = 3'h7;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_main;
    t_rx;
    t_gate;
    end_of_test;
  end

  // Watchdog
  initial
  begin
    repeat (5000) @(posedge aclk);
    num_errors++;
    end_of_test;
  end
endmodule
